// file: bench/cpu_reset_and_irq_vectoring_tb.sv
// Self-checking bench for the exception unit.
// Assumes rvx_partner answers acknowledges.
`timescale 1ns/10ps
`default_nettype none
module cpu_reset_and_irq_vectoring_tb import rvx_pkg::*;;
    // ****************************************
    // Stimulus and model
    // ****************************************
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cpuReset = 1'b1;
    logic config_strap = 1'b1;
    logic nmiReq = 1'b0;
    logic intReq = 1'b0;
    logic intEnable = 1'b0;
    rvx_cyc_t cycKind = CYC_IDLE;
    logic [19:0] cycAddr = 20'h00000;
    logic cycByte = 1'b0;
    logic [3:0] ackWait = 4'h0;
    logic [7:0] nextType = 8'h00;
    logic ackTypeValid, vecTaken, running, initBusy, fetchStart, intaActive, hiEnN, bitZero;
    logic [7:0] ackType;
    logic [19:0] fetchAddr;
    logic [2:0] busStatus;
    rvx_vec_t vecOut;
    rvx_ctl_t busCtl;
    logic [28:0] expQ[$];
    rvx_cyc_t kinds[4] = '{CYC_MEMRD, CYC_MEMWR, CYC_IORD, CYC_IOWR};
    logic [2:0] codes[4] = '{STAT_MEMRD, STAT_MEMWR, STAT_IORD, STAT_IOWR};
    int n_mismatch = 0;
    int checks_done = 0;
    rvx_exception_unit DUT (.sys_clk(sys_clk), .arst_n(arst_n), .cpuReset(cpuReset), .config_strap(config_strap),
        .nmiReq(nmiReq), .intReq(intReq), .intEnable(intEnable), .ackType(ackType), .ackTypeValid(ackTypeValid),
        .vecTaken(vecTaken), .cycKind(cycKind), .cycAddr(cycAddr), .cycByte(cycByte), .running(running),
        .initBusy(initBusy), .fetchStart(fetchStart), .fetchAddr(fetchAddr), .vecOut(vecOut),
        .intaActive(intaActive), .high_byte_lane_enable_n(hiEnN), .address_bit_zero(bitZero),
        .busCtl(busCtl), .busStatus(busStatus));
    rvx_partner u_partner (.sys_clk(sys_clk), .arst_n(arst_n), .intaActive(intaActive), .vecOut(vecOut),
        .ackWait(ackWait), .nextType(nextType), .ackTypeValid(ackTypeValid), .ackType(ackType), .vecTaken(vecTaken));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic bad(input string m);
        n_mismatch++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e) bad("flag differs");
    endtask
    task automatic cmp_vec(input logic [28:0] g, input logic [28:0] e);
        checks_done++;
        if (g !== e) bad("vector differs");
    endtask
    task automatic cmp_bus(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) bad("bus outputs differ");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(negedge sys_clk) begin
        if (vecOut.valid === 1'b1 && vecTaken === 1'b1) begin
            if (expQ.size() == 0) bad("unexpected vector");
            else cmp_vec({vecOut.nmi, vecOut.typeNum, vecOut.vecAddr}, expQ.pop_front());
        end
    end
    task automatic boot();
        int n;
        cpuReset <= 1'b1;
        tick(6);
        @(negedge sys_clk);
        cmp_bit(running, 1'b0);
        cmp_bit(intaActive, 1'b0);
        tick(1);
        cpuReset <= 1'b0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (fetchStart !== 1'b1 && n < 40);
        cmp_bit(n == INIT_SEQ_CLK + 4, 1'b1);
        cmp_bit(running, 1'b1);
        cmp_vec({9'h000, fetchAddr}, {9'h000, 20'hffff0});
        tick(3);
    endtask
    task automatic irq(input logic [7:0] t);
        int n;
        int seenAt;
        nextType <= t;
        ackWait <= 4'($urandom_range(3));
        intEnable <= 1'b1;
        intReq <= 1'b1;
        expQ.push_back({1'b0, t, 20'(int'(t) * 4)});
        n = 0;
        seenAt = 0;
        do begin
            @(negedge sys_clk);
            n++;
            if (seenAt != 0 && n == seenAt + 1) begin
                cmp_bit(config_strap ? busCtl.intaN : (busStatus != STAT_INTA), 1'b0);
                cmp_bit(hiEnN & bitZero, 1'b1);
            end
            if (seenAt == 0 && intaActive === 1'b1) seenAt = n;
            tick(1);
            if (seenAt != 0) intReq <= 1'b0;
        end while (expQ.size() != 0 && n < 40);
        if (seenAt == 0) intReq <= 1'b0;
        tick(2);
        cmp_bit(expQ.size() == 0, 1'b1);
    endtask
    task automatic lanes();
        int j;
        logic b, a;
        for (int i = 0; i < 16; i++) begin
            j = $urandom_range(3);
            b = 1'($urandom);
            a = b & 1'($urandom);
            config_strap <= i[0];
            cycKind <= kinds[j];
            cycByte <= b;
            cycAddr <= {19'($urandom), a};
            tick(1);
            @(negedge sys_clk);
            cmp_bus({hiEnN, bitZero, busStatus, busCtl.readN, busCtl.writeN, busCtl.memIo},
                {b ? {~a, a} : 2'h0, i[0] ? STAT_PASSIVE : codes[j], !(i[0] && !j[0]), !(i[0] && j[0]),
                i[0] && j < 2});
            tick(1);
        end
        cycKind <= CYC_IDLE;
        config_strap <= 1'b1;
    endtask
    initial begin
        void'($urandom(32'hea71db55));
        tick(12);
        arst_n <= 1'b1;
        tick(POWERUP_CYC);
        boot();
        for (int i = 0; i < 6; i++) irq(8'($urandom));
        config_strap <= 1'b0;
        irq(8'hff);
        config_strap <= 1'b1;
        intEnable <= 1'b0;
        intReq <= 1'b1;
        tick(20);
        @(negedge sys_clk);
        cmp_bit(intaActive, 1'b0);
        tick(1);
        expQ.push_back({1'b1, 8'h02, 20'h00008});
        nmiReq <= 1'b1;
        tick(3);
        nmiReq <= 1'b0;
        tick(10);
        cmp_bit(expQ.size() == 0, 1'b1);
        lanes();
        ackWait <= 4'h8;
        intEnable <= 1'b1;
        tick(4);
        intReq <= 1'b0;
        boot();
        irq(8'h00);
        end_sim();
    end
    initial begin
        // About thirty times the expected run
        #2_000_000;
        bad("timeout");
        end_sim();
    end
endmodule
bind rvx_exception_unit rvx_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .cpuReset(cpuReset),
    .config_strap(config_strap), .intReq(intReq), .intEnable(intEnable), .ackType(ackType),
    .ackTypeValid(ackTypeValid), .vecTaken(vecTaken), .cycKind(cycKind), .cycAddr(cycAddr), .cycByte(cycByte),
    .running(running), .initBusy(initBusy), .fetchStart(fetchStart), .fetchAddr(fetchAddr), .vecOut(vecOut),
    .intaActive(intaActive), .high_byte_lane_enable_n(high_byte_lane_enable_n),
    .address_bit_zero(address_bit_zero), .busCtl(busCtl));
`default_nettype wire

// file: bench/rvx_chk_sva.sv
// Port assertions for the exception unit.
// Assumes it is bound to rvx_exception_unit.
`timescale 1ns/10ps
`default_nettype none
module rvx_chk import rvx_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cpuReset,
    input wire logic config_strap,
    input wire logic intReq,
    input wire logic intEnable,
    input wire logic [7:0] ackType,
    input wire logic ackTypeValid,
    input wire logic vecTaken,
    input wire rvx_cyc_t cycKind,
    input wire logic [19:0] cycAddr,
    input wire logic cycByte,
    input wire logic running,
    input wire logic initBusy,
    input wire logic fetchStart,
    input wire logic [19:0] fetchAddr,
    input wire rvx_vec_t vecOut,
    input wire logic intaActive,
    input wire logic high_byte_lane_enable_n,
    input wire logic address_bit_zero,
    input wire rvx_ctl_t busCtl
);
    // ****************************************
    // Checks
    // ****************************************
    logic [1:0] laneExp;
    logic cycReal;
    always_comb begin
        laneExp = cycByte ? {~cycAddr[0], cycAddr[0]} : 2'h0;
        cycReal = (cycKind != CYC_IDLE) && (cycKind != CYC_INTA) && (cycByte || !cycAddr[0]);
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    chk_init_len: assert property ($rose(initBusy) |->
        initBusy[*5] ##1 initBusy[*5] ##1 (running && fetchStart))
        else $error("init sequence length wrong");
    chk_sync_wait: assert property ($fell(cpuReset) |-> !initBusy ##1 !initBusy ##[1:3] initBusy)
        else $error("reset release not synchronised");
    chk_dormant: assert property (cpuReset[*4] |-> !running && !initBusy && !intaActive && !fetchStart)
        else $error("activity while reset high");
    chk_boot_addr: assert property (fetchStart |-> (running && fetchAddr == BOOT_ADDR) ##1 !fetchStart)
        else $error("first fetch wrong");
    chk_vec_addr: assert property (vecOut.valid |-> vecOut.vecAddr == {10'h000, vecOut.typeNum, 2'h0})
        else $error("vector address wrong");
    chk_ack_type: assert property (intaActive && ackTypeValid |=>
        vecOut.valid && !vecOut.nmi && !intaActive && vecOut.typeNum == $past(ackType))
        else $error("acknowledge type not used");
    chk_vec_hold: assert property (vecOut.valid && !vecTaken |=> vecOut.valid && $stable(vecOut))
        else $error("vector dropped early");
    chk_mask_gate: assert property ($rose(intaActive) |-> $past(intReq && intEnable && running))
        else $error("masked interrupt taken");
    chk_lane_code: assert property (running && cycReal |=>
        {high_byte_lane_enable_n, address_bit_zero} == $past(laneExp))
        else $error("byte lanes wrong");
    chk_max_mode: assert property (!config_strap && $past(!config_strap) |-> busCtl.readN && busCtl.writeN)
        else $error("controls driven in max mode");
endmodule
`default_nettype wire

// file: bench/rvx_partner.sv
// Interrupt controller stand-in for the acknowledge handshake.
// Assumes the unit's outputs are registered on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module rvx_partner import rvx_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic intaActive,
    input wire rvx_vec_t vecOut,
    input wire logic [3:0] ackWait,
    input wire logic [7:0] nextType,
    output logic ackTypeValid,
    output logic [7:0] ackType,
    output logic vecTaken
);
    // ****************************************
    // Acknowledge answer
    // ****************************************
    logic [3:0] cnt;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 4'h0;
            ackTypeValid <= 1'b0;
            ackType <= 8'h00;
            vecTaken <= 1'b0;
        end else begin
            vecTaken <= vecOut.valid && !vecTaken;
            cnt <= (intaActive && !ackTypeValid) ? cnt + 4'h1 : 4'h0;
            if (ackTypeValid) begin
                ackTypeValid <= 1'b0;
                ackType <= ~ackType;
            end else if (intaActive && cnt >= ackWait) begin
                ackTypeValid <= 1'b1;
                ackType <= nextType;
            end
        end
    end
endmodule
`default_nettype wire

// file: design/rvx_exception_unit.sv
// Reset sequencing, interrupt vectoring and byte-lane selection.
// Assumes all inputs except cpuReset are synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Rising reset aborts all activity; unit stays dormant while high.
// - Falling reset starts a ten-clock initialisation sequence.
// - First fetch after initialisation comes from FFFF0 hex.
// - Reset input is synchronised internally; may arrive asynchronously.
// - One non-maskable and one maskable interrupt, the latter software disabled.
// - Vectors come from 256 four-byte pointers at 0 to 3FF hex.
// - Acknowledged device supplies an 8-bit type selecting the vector entry.
// - Lane enable and address bit zero encode word, upper, lower, none.
// - Minimum mode drives bus controls; maximum mode drives coded status.
module rvx_exception_unit import rvx_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cpuReset,
    input wire logic config_strap,
    input wire logic nmiReq,
    input wire logic intReq,
    input wire logic intEnable,
    input wire logic [7:0] ackType,
    input wire logic ackTypeValid,
    input wire logic vecTaken,
    input wire rvx_cyc_t cycKind,
    input wire logic [19:0] cycAddr,
    input wire logic cycByte,
    output logic running,
    output logic initBusy,
    output logic fetchStart,
    output logic [19:0] fetchAddr,
    output rvx_vec_t vecOut,
    output logic intaActive,
    output logic high_byte_lane_enable_n,
    output logic address_bit_zero,
    output rvx_ctl_t busCtl,
    output logic [2:0] busStatus
);
    // ****************************************
    // Reset sequencer
    // ****************************************
    typedef enum logic [1:0] {RS_DORMANT, RS_INIT, RS_RUN} rvx_rst_t;

    rvx_rst_t rstState;
    rvx_rst_t next_rstState;
    logic [3:0] initCnt;
    logic [3:0] next_initCnt;
    logic resetSync;
    logic [1:0] sinceRun;
    logic [1:0] next_sinceRun;
    logic next_running;
    logic next_initBusy;
    logic next_fetchStart;
    logic [19:0] next_fetchAddr;

    rvx_sync uSync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .din(cpuReset),
        .dout(resetSync)
    );

    always_comb begin
        next_rstState = rstState;
        next_initCnt = initCnt;
        next_fetchStart = 1'b0;
        next_fetchAddr = fetchAddr;
        next_sinceRun = sinceRun;
        unique case (rstState)
            RS_DORMANT: begin
                next_initCnt = 4'h0;
                if (!resetSync) begin
                    next_rstState = RS_INIT;
                end
            end
            RS_INIT: begin
                next_initCnt = initCnt + 4'h1;
                if (initCnt == INIT_LAST) begin
                    next_rstState = RS_RUN;
                    next_fetchStart = 1'b1;
                    next_fetchAddr = BOOT_ADDR;
                end
            end
            RS_RUN: begin
                if (sinceRun != 2'h3) begin
                    next_sinceRun = sinceRun + 2'h1;
                end
            end
        endcase
        if (resetSync) begin
            next_rstState = RS_DORMANT;
            next_fetchStart = 1'b0;
            next_sinceRun = 2'h0;
        end
        next_running = (next_rstState == RS_RUN);
        next_initBusy = (next_rstState == RS_INIT);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstState <= RS_DORMANT;
            initCnt <= 4'h0;
            sinceRun <= 2'h0;
            running <= 1'b0;
            initBusy <= 1'b0;
            fetchStart <= 1'b0;
            fetchAddr <= BOOT_ADDR;
        end else begin
            rstState <= next_rstState;
            initCnt <= next_initCnt;
            sinceRun <= next_sinceRun;
            running <= next_running;
            initBusy <= next_initBusy;
            fetchStart <= next_fetchStart;
            fetchAddr <= next_fetchAddr;
        end
    end

    // ****************************************
    // Interrupt vectoring
    // ****************************************
    logic nmiPrev;
    logic nmiPend;
    logic next_nmiPend;
    logic next_intaActive;
    rvx_vec_t next_vecOut;
    logic nmiOk;

    assign nmiOk = running && (sinceRun >= 2'h1);

    always_comb begin
        next_nmiPend = nmiPend;
        next_intaActive = intaActive;
        next_vecOut = vecOut;
        if (vecTaken) begin
            next_vecOut.valid = 1'b0;
        end
        if (nmiOk && nmiReq && !nmiPrev) begin
            next_nmiPend = 1'b1;
        end
        if (!vecOut.valid || vecTaken) begin
            if (next_nmiPend) begin
                next_nmiPend = 1'b0;
                next_vecOut.valid = 1'b1;
                next_vecOut.nmi = 1'b1;
                next_vecOut.typeNum = 8'h02;
                next_vecOut.vecAddr = vec_addr(8'h02);
            end else if (intaActive && ackTypeValid) begin
                next_intaActive = 1'b0;
                next_vecOut.valid = 1'b1;
                next_vecOut.nmi = 1'b0;
                next_vecOut.typeNum = ackType;
                next_vecOut.vecAddr = vec_addr(ackType);
            end else if (running && intReq && intEnable && !intaActive) begin
                next_intaActive = 1'b1;
            end
        end
        if (!running || resetSync) begin
            next_nmiPend = 1'b0;
            next_intaActive = 1'b0;
            next_vecOut = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            nmiPrev <= 1'b0;
            nmiPend <= 1'b0;
            intaActive <= 1'b0;
            vecOut <= '0;
        end else begin
            nmiPrev <= nmiReq;
            nmiPend <= next_nmiPend;
            intaActive <= next_intaActive;
            vecOut <= next_vecOut;
        end
    end

    // ****************************************
    // Byte lanes and bus control
    // ****************************************
    logic next_hiEnN;
    logic next_a0;
    rvx_ctl_t next_busCtl;
    rvx_cyc_t effKind;
    logic [2:0] next_busStatus;
    logic [1:0] lane;

    always_comb begin
        effKind = running ? cycKind : CYC_IDLE;
        if (intaActive && running) begin
            effKind = CYC_INTA;
        end
        if (effKind == CYC_IDLE || effKind == CYC_INTA) begin
            lane = LANE_NONE;
        end else if (!cycByte) begin
            lane = LANE_WORD;
        end else if (cycAddr[0]) begin
            lane = LANE_UPPER;
        end else begin
            lane = LANE_LOWER;
        end
        next_hiEnN = lane[1];
        next_a0 = lane[0];
        next_busCtl = '{readN: 1'b1, writeN: 1'b1, memIo: 1'b0, intaN: 1'b1};
        next_busStatus = STAT_PASSIVE;
        unique case (effKind)
            CYC_IDLE: ;
            CYC_MEMRD: begin
                next_busCtl.readN = 1'b0;
                next_busCtl.memIo = 1'b1;
                next_busStatus = STAT_MEMRD;
            end
            CYC_MEMWR: begin
                next_busCtl.writeN = 1'b0;
                next_busCtl.memIo = 1'b1;
                next_busStatus = STAT_MEMWR;
            end
            CYC_IORD: begin
                next_busCtl.readN = 1'b0;
                next_busStatus = STAT_IORD;
            end
            CYC_IOWR: begin
                next_busCtl.writeN = 1'b0;
                next_busStatus = STAT_IOWR;
            end
            CYC_INTA: begin
                next_busCtl.intaN = 1'b0;
                next_busStatus = STAT_INTA;
            end
            default: ;
        endcase
        if (config_strap) begin
            next_busStatus = STAT_PASSIVE;
        end else begin
            next_busCtl = '{readN: 1'b1, writeN: 1'b1, memIo: 1'b0, intaN: 1'b1};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            high_byte_lane_enable_n <= 1'b1;
            address_bit_zero <= 1'b1;
            busCtl <= '{readN: 1'b1, writeN: 1'b1, memIo: 1'b0, intaN: 1'b1};
            busStatus <= STAT_PASSIVE;
        end else begin
            high_byte_lane_enable_n <= next_hiEnN;
            address_bit_zero <= next_a0;
            busCtl <= next_busCtl;
            busStatus <= next_busStatus;
        end
    end
endmodule
`default_nettype wire

// file: design/rvx_sync.sv
// Two-stage synchroniser for the reset request level.
// Assumes the input may change at any time.
`timescale 1ns/10ps
`default_nettype none
module rvx_sync import rvx_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic din,
    output logic dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= 1'b1;
            dout <= 1'b1;
        end else begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

// file: shared/rvx_pkg.sv
// Package for the reset, interrupt vectoring and byte-lane unit.
// Assumes a single 10 MHz processor clock.
package rvx_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_MIN_CLK = 4;
    localparam int INIT_SEQ_CLK = 10;
    localparam int POWERUP_US = 50;
    localparam int POWERUP_CYC = (POWERUP_US * 1000) / CLK_PERIOD_NS;
    localparam logic [3:0] INIT_LAST = 4'(INIT_SEQ_CLK - 1);

    // ****************************************
    // Addresses
    // ****************************************
    localparam logic [19:0] BOOT_ADDR = 20'hffff0;
    localparam logic [19:0] VEC_TABLE_BASE = 20'h00000;
    localparam logic [19:0] VEC_TABLE_LAST = 20'h003ff;
    localparam int VEC_ENTRY_BYTES = 4;
    localparam int VEC_SHIFT = 2;

    // ****************************************
    // Byte lanes
    // ****************************************
    localparam logic [1:0] LANE_WORD = 2'h0;
    localparam logic [1:0] LANE_UPPER = 2'h1;
    localparam logic [1:0] LANE_LOWER = 2'h2;
    localparam logic [1:0] LANE_NONE = 2'h3;

    // Maximum mode status codes
    localparam logic [2:0] STAT_INTA = 3'h0;
    localparam logic [2:0] STAT_IORD = 3'h1;
    localparam logic [2:0] STAT_IOWR = 3'h2;
    localparam logic [2:0] STAT_MEMRD = 3'h5;
    localparam logic [2:0] STAT_MEMWR = 3'h6;
    localparam logic [2:0] STAT_PASSIVE = 3'h7;

    typedef enum logic [2:0] {
        CYC_IDLE, CYC_MEMRD, CYC_MEMWR, CYC_IORD, CYC_IOWR, CYC_INTA
    } rvx_cyc_t;

    typedef struct packed {
        logic readN;
        logic writeN;
        logic memIo;
        logic intaN;
    } rvx_ctl_t;

    typedef struct packed {
        logic valid;
        logic nmi;
        logic [7:0] typeNum;
        logic [19:0] vecAddr;
    } rvx_vec_t;

    function automatic logic [19:0] vec_addr(input logic [7:0] typeNum);
        vec_addr = VEC_TABLE_BASE | {10'h000, typeNum, 2'h0};
    endfunction

    function automatic logic [1:0] lane_code(input logic hiEnN, input logic a0);
        lane_code = {hiEnN, a0};
    endfunction
endpackage
